// [opmode_pkg.sv]
// package: constants and types for the operating mode controller
package opmode_pkg;
   // register byte offsets (word aligned)
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_WAKE = 4'h4;
   localparam logic [3:0] REG_STATUS = 4'h8;
   localparam logic [3:0] REG_CMD = 4'hC;
   // control register fields
   localparam int CTRL_STOP_EN = 0;
   localparam int CTRL_IREF_STOP = 1;
   localparam int CTRL_LV_EN = 2;
   localparam int CTRL_LV_STOP = 3;
   localparam int CTRL_DBG_EN = 4;
   localparam int CTRL_EXT_EN = 5;
   localparam int CTRL_EXT_STOP = 6;
   localparam int CTRL_ADC_ASYNC = 7;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   // wake register fields
   localparam int WAKE_RATE_LSB = 0;
   localparam int WAKE_CLKSEL = 3;
   localparam logic [2:0] RATE_OFF = 3'h0;
   // addresses
   localparam logic [15:0] START_ADDR = 16'h3FFD;
   localparam logic [7:0] JUMP_OPCODE = 8'hBC;
   // debug serial timing
   localparam int DBG_CLKS_PER_BIT = 16;
   // command codes from the debug controller
   typedef enum logic [2:0] {
      CMD_NONE = 3'b000,
      CMD_MEM = 3'b001,
      CMD_MEM_STATUS = 3'b010,
      CMD_BACKGROUND = 3'b011,
      CMD_REG = 3'b100,
      CMD_TRACE = 3'b101,
      CMD_GO = 3'b110,
      CMD_FORCE_RESET = 3'b111
   } dbg_cmd_t;
   typedef enum logic [1:0] {
      MODE_RUN = 2'b00,
      MODE_DEBUG = 2'b01,
      MODE_WAIT = 2'b10,
      MODE_STOP = 2'b11
   } mode_t;
endpackage : opmode_pkg

// [operating_mode_controller.sv]
// operating mode controller: run, debug, wait and stop sequencing
//
// Design decisions made here: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ns
// Functional notes
// - mode pin high at reset release gives run
// - run start fetch at fixed start address
// - debug entry: pin low, force reset, commands
// - debug mode suspends cpu awaiting commands
// - memory and background commands in run/debug
// - register, trace, resume only in debug
// - wait stops cpu clock only
// - interrupt leaves wait, pc advances one
// - low power accepts background, status-error memory
// - background command in wait enters debug
// - stop instruction with enable enters stop
// - stop without enable forces illegal-opcode reset
// - stop holds state, clock source off, regulator standby
// - stop exits on reset, periodic wake, enabled interrupts
// - interrupt exit continues at next instruction
// - periodic wake about 1 kHz, rate zero disables
// - stop, detector off, clksel one: oscillator off
// - ext ref enable and stop enable keep it running
// - converter and crystal need detector bits in stop
// - debug enable keeps debug clock, reference and regulation in stop
// - detector bits keep regulator; clock needs stop enable
// - debug link 16 clocks per bit
module operating_mode_controller #(
   parameter int WAKE_DIV = 20000
) (
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic i_mode_pin,
   input wire logic i_wait_instr,
   input wire logic i_stop_instr,
   input wire logic i_halt_instr,
   input wire logic i_breakpoint,
   input wire opmode_pkg::dbg_cmd_t i_dbg_cmd,
   input wire logic i_dbg_cmd_valid,
   input wire logic [7:0] i_irq,
   input wire logic [7:0] i_irq_enable,
   input wire logic [3:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   output opmode_pkg::mode_t o_mode,
   output logic o_cpu_clk_en,
   output logic o_sys_clk_en,
   output logic o_dbg_clk_en,
   output logic o_iref_on,
   output logic o_lpo_on,
   output logic o_ext_ref_on,
   output logic o_crystal_oscillator_on,
   output logic o_adc_on,
   output logic o_reg_full,
   output logic o_pc_load,
   output logic [15:0] o_pc_value,
   output logic o_pc_advance,
   output logic o_illegal_reset,
   output logic o_dbg_cmd_accept,
   output logic o_dbg_cmd_error,
   output logic o_dbg_bit_tick,
   output logic o_periodic_wake
);
   import opmode_pkg::*;

   initial begin
      if (WAKE_DIV < 2) $error("WAKE_DIV too small");
   end

   localparam int WCW = $clog2(WAKE_DIV);

   typedef struct packed {
      logic [2:0] pin_sync;
      logic [1:0] fill;
      logic pin_level;
      logic boot;
      mode_t mode;
      logic [7:0] ctrl;
      logic [3:0] wake_cfg;
      logic wake_flag;
      logic [WCW-1:0] wake_cnt;
      logic [3:0] bit_cnt;
      logic [31:0] rdata;
      logic wreq;
      logic cpu_clk_en, sys_clk_en, dbg_clk_en;
      logic iref_on, lpo_on, ext_ref_on, crystal_oscillator_on, adc_on, reg_full;
      logic pc_load;
      logic [15:0] pc_value;
      logic pc_advance, illegal_reset, cmd_accept, cmd_error, bit_tick;
   } state_t;

   state_t cur;
   state_t next_s;

   // ------------------------------------------------------------
   // behaviour overview
   // ------------------------------------------------------------
   // boot:
   //    the mode pin is only trusted once every synchroniser stage
   //    has been loaded since reset; a cleared pipeline would look
   //    like a settled low level and force debug on every boot.
   //    the fill counter stops at the stage count and stays there.
   // run:
   //    debug entry requests win over wait, wait wins over stop.
   //    a stop with the enable bit clear never reaches stop; it
   //    raises the illegal reset pulse and reloads the start address.
   // debug:
   //    the cpu clock stays gated; every command is served and
   //    the resume command hands control back to the program.
   // wait and stop:
   //    only the background, force reset and status-flagged memory
   //    commands are taken; the last always reports an error so
   //    the host knows no memory cycle happened.
   //    any enabled interrupt or a periodic tick wakes the core unless a
   //    debug entry wins in the same cycle; the core then advances one
   //    step instead of fetching a vector.
   // power controls:
   //    they follow the next mode so that the gates switch at the
   //    same edge as the mode itself; a consumer never sees a
   //    clock running in a mode that forbids it.
   // periodic wake:
   //    the divider only runs while the rate field is nonzero, so
   //    a disabled timer costs no toggling; the flag is sticky and
   //    a tick that meets a register clear in one cycle keeps it set.
   // register bus:
   //    one wait cycle per access keeps the decode registered; the
   //    read word stands until the next answer replaces it.
   // debug bit timing:
   //    a free running tick every bit period; the serial engine
   //    itself lives outside this block.
   // limitations:
   //    the rate field only gates the timer; every nonzero rate
   //    uses the same divider, a trade of precision for area.
   //    unmapped offsets read as zero and ignore writes.

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      logic agree;
      logic irq_any;
      logic low_pwr;
      logic lv_both;
      logic stop_en;
      logic dbg_en;
      logic nonintr;
      logic active_cmd;
      logic wake_tick;
      agree = 1'b0;
      irq_any = 1'b0;
      low_pwr = 1'b0;
      lv_both = 1'b0;
      stop_en = 1'b0;
      dbg_en = 1'b0;
      nonintr = 1'b0;
      active_cmd = 1'b0;
      wake_tick = 1'b0;
      next_s = cur;
      // pin synchroniser: stage 0 feeds only stage 1
      next_s.pin_sync = {cur.pin_sync[1:0], i_mode_pin};
      agree = (cur.pin_sync[1] == cur.pin_sync[2]);
      // count pipeline loads so a cleared synchroniser is not trusted
      if (cur.fill != 2'($bits(cur.pin_sync))) begin
         next_s.fill = cur.fill + 2'h1;
      end
      if (agree) begin
         next_s.pin_level = cur.pin_sync[2];
      end
      // single-cycle pulses default low
      next_s.pc_load = 1'b0;
      next_s.pc_advance = 1'b0;
      next_s.illegal_reset = 1'b0;
      next_s.cmd_accept = 1'b0;
      next_s.cmd_error = 1'b0;
      irq_any = |(i_irq & i_irq_enable);
      low_pwr = (cur.mode == MODE_WAIT) || (cur.mode == MODE_STOP);
      lv_both = cur.ctrl[CTRL_LV_EN] & cur.ctrl[CTRL_LV_STOP];
      stop_en = cur.ctrl[CTRL_STOP_EN];
      dbg_en = cur.ctrl[CTRL_DBG_EN];
      nonintr = (i_dbg_cmd == CMD_MEM) || (i_dbg_cmd == CMD_MEM_STATUS) ||
                (i_dbg_cmd == CMD_BACKGROUND);
      active_cmd = (i_dbg_cmd == CMD_REG) || (i_dbg_cmd == CMD_TRACE) ||
                   (i_dbg_cmd == CMD_GO);

      // debug bit timing, one tick every 16 clocks
      next_s.bit_cnt = cur.bit_cnt + 4'h1;
      next_s.bit_tick = (cur.bit_cnt == 4'(DBG_CLKS_PER_BIT - 1));

      // periodic wake divider, roughly 1 kHz from the core clock
      if (cur.wake_cfg[2:0] == RATE_OFF) begin
         next_s.wake_cnt = '0;
      end else if (cur.wake_cnt == WCW'(WAKE_DIV - 1)) begin
         next_s.wake_cnt = '0;
         wake_tick = 1'b1;
      end else begin
         next_s.wake_cnt = cur.wake_cnt + WCW'(1);
      end
      if (wake_tick) begin
         next_s.wake_flag = 1'b1;  // set wins over the register clear below, not the wake exit
      end

      // boot mode is picked once the pin has settled after reset
      if (cur.boot) begin
         if (agree && (cur.fill == 2'($bits(cur.pin_sync)))) begin
            next_s.boot = 1'b0;
            next_s.pc_load = 1'b1;
            next_s.pc_value = START_ADDR;
            if (cur.pin_sync[2]) begin
               next_s.mode = MODE_RUN;
            end else begin
               next_s.mode = MODE_DEBUG;
            end
         end
      end else if (i_dbg_cmd_valid && i_dbg_cmd == CMD_FORCE_RESET) begin
         next_s.cmd_accept = 1'b1;
         next_s.pc_load = 1'b1;
         next_s.pc_value = START_ADDR;
         next_s.mode = MODE_DEBUG;
      end else begin
         case (cur.mode)
            MODE_RUN: begin
               if (i_dbg_cmd_valid) begin
                  next_s.cmd_accept = nonintr;
                  next_s.cmd_error = active_cmd;
               end
               if ((i_dbg_cmd_valid && i_dbg_cmd == CMD_BACKGROUND) ||
                   i_halt_instr || i_breakpoint) begin
                  next_s.mode = MODE_DEBUG;
               end else if (i_wait_instr) begin
                  next_s.mode = MODE_WAIT;
               end else if (i_stop_instr) begin
                  if (stop_en) begin
                     next_s.mode = MODE_STOP;
                  end else begin
                     next_s.illegal_reset = 1'b1;
                     next_s.pc_load = 1'b1;
                     next_s.pc_value = START_ADDR;
                  end
               end
            end
            MODE_DEBUG: begin
               // cpu suspended, all commands served
               if (i_dbg_cmd_valid) begin
                  next_s.cmd_accept = nonintr | active_cmd;
                  if (i_dbg_cmd == CMD_GO) begin
                     next_s.mode = MODE_RUN;
                  end
               end
            end
            MODE_WAIT, MODE_STOP: begin
               if (i_dbg_cmd_valid) begin
                  next_s.cmd_accept = (i_dbg_cmd == CMD_BACKGROUND) ||
                                      (i_dbg_cmd == CMD_MEM_STATUS);
                  next_s.cmd_error = (i_dbg_cmd != CMD_BACKGROUND);
               end
               if (i_dbg_cmd_valid && i_dbg_cmd == CMD_BACKGROUND &&
                   (cur.mode == MODE_WAIT || dbg_en)) begin
                  next_s.mode = MODE_DEBUG;
               end else if (irq_any || cur.wake_flag || wake_tick) begin
                  next_s.mode = MODE_RUN;
                  next_s.pc_advance = 1'b1;
                  next_s.wake_flag = 1'b0;
               end
            end
            default: begin
               next_s.mode = MODE_RUN;
            end
         endcase
      end

      // clock gates and power controls follow the next mode
      next_s.cpu_clk_en = (next_s.mode == MODE_RUN);
      next_s.sys_clk_en = (next_s.mode != MODE_STOP);
      if (next_s.mode == MODE_STOP) begin
         next_s.dbg_clk_en = dbg_en;
         next_s.reg_full = dbg_en | lv_both;
         next_s.iref_on = dbg_en | (cur.ctrl[CTRL_IREF_STOP] & lv_both);
         next_s.lpo_on = !(!lv_both && cur.wake_cfg[WAKE_CLKSEL]);
         next_s.ext_ref_on = cur.ctrl[CTRL_EXT_EN] & cur.ctrl[CTRL_EXT_STOP];
         next_s.crystal_oscillator_on = cur.ctrl[CTRL_EXT_EN] & lv_both;
         next_s.adc_on = cur.ctrl[CTRL_ADC_ASYNC] & lv_both;
      end else begin
         next_s.dbg_clk_en = 1'b1;
         next_s.reg_full = 1'b1;
         next_s.iref_on = 1'b1;
         next_s.lpo_on = 1'b1;
         next_s.ext_ref_on = cur.ctrl[CTRL_EXT_EN];
         next_s.crystal_oscillator_on = cur.ctrl[CTRL_EXT_EN];
         next_s.adc_on = 1'b1;
      end

      // avalon slave: one wait cycle, then answer
      next_s.wreq = 1'b1;
      if ((i_avs_read || i_avs_write) && cur.wreq) begin
         next_s.wreq = 1'b0;
         next_s.rdata = 32'h0000_0000;
         if (i_avs_read) begin
            case (i_avs_address)
               REG_CTRL: next_s.rdata = {24'h00_0000, cur.ctrl};
               REG_WAKE: next_s.rdata = {27'h000_0000, cur.wake_flag, cur.wake_cfg};
               REG_STATUS: next_s.rdata = {29'h0000_0000, low_pwr, cur.mode};
               default: next_s.rdata = 32'h0000_0000;
            endcase
         end else begin
            case (i_avs_address)
               REG_CTRL: next_s.ctrl = i_avs_writedata[7:0];
               REG_WAKE: begin
                  next_s.wake_cfg = i_avs_writedata[3:0];
                  if (i_avs_writedata[4] && !wake_tick) begin
                     next_s.wake_flag = 1'b0;  // write one clears
                  end
               end
               default: begin
               end
            endcase
         end
      end
   end

   // ------------------------------------------------------------
   // state register
   // ------------------------------------------------------------
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         cur <= '0;
         cur.boot <= 1'b1;
         cur.mode <= MODE_DEBUG;  // cpu held until the pin decides
         cur.ctrl <= CTRL_RESET;
         cur.wreq <= 1'b1;
         cur.dbg_clk_en <= 1'b1;
         cur.sys_clk_en <= 1'b1;
         cur.iref_on <= 1'b1;
         cur.lpo_on <= 1'b1;
         cur.reg_full <= 1'b1;
         cur.adc_on <= 1'b1;
      end else begin
         cur <= next_s;
      end
   end

   // outputs straight from the state flops
   assign o_mode = cur.mode;
   assign o_cpu_clk_en = cur.cpu_clk_en;
   assign o_sys_clk_en = cur.sys_clk_en;
   assign o_dbg_clk_en = cur.dbg_clk_en;
   assign o_iref_on = cur.iref_on;
   assign o_lpo_on = cur.lpo_on;
   assign o_ext_ref_on = cur.ext_ref_on;
   assign o_crystal_oscillator_on = cur.crystal_oscillator_on;
   assign o_adc_on = cur.adc_on;
   assign o_reg_full = cur.reg_full;
   assign o_pc_load = cur.pc_load;
   assign o_pc_value = cur.pc_value;
   assign o_pc_advance = cur.pc_advance;
   assign o_illegal_reset = cur.illegal_reset;
   assign o_dbg_cmd_accept = cur.cmd_accept;
   assign o_dbg_cmd_error = cur.cmd_error;
   assign o_dbg_bit_tick = cur.bit_tick;
   assign o_periodic_wake = cur.wake_flag;
   assign o_avs_readdata = cur.rdata;
   assign o_avs_waitrequest = cur.wreq;
endmodule : operating_mode_controller

// [opmode_checker_properties.sv]
// checker: concurrent properties of the operating mode controller
`timescale 1ns/1ns
module opmode_checker
   import opmode_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic i_wait_instr,
   input wire logic i_stop_instr,
   input wire logic i_halt_instr,
   input wire logic i_breakpoint,
   input wire opmode_pkg::dbg_cmd_t i_dbg_cmd,
   input wire logic i_dbg_cmd_valid,
   input wire logic [7:0] i_irq,
   input wire logic [7:0] i_irq_enable,
   input wire logic [3:0] i_avs_address,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic o_avs_waitrequest,
   input wire opmode_pkg::mode_t o_mode,
   input wire logic o_cpu_clk_en,
   input wire logic o_pc_advance,
   input wire logic o_illegal_reset,
   input wire logic o_dbg_cmd_accept,
   input wire logic o_dbg_cmd_error,
   input wire logic o_dbg_bit_tick
);
   logic stop_en;
   logic quiet;
   logic wake;
   // shadow of the stop enable bit, taken when a control write completes
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         stop_en <= 1'b0;
      end else if (i_avs_write && !o_avs_waitrequest && i_avs_address == REG_CTRL) begin
         stop_en <= i_avs_writedata[CTRL_STOP_EN];
      end
   end
   // run with no debug entry pending, which would win over wait and stop
   assign quiet = o_mode == MODE_RUN && !i_halt_instr && !i_breakpoint && !i_dbg_cmd_valid;
   assign wake = |(i_irq & i_irq_enable) && !i_dbg_cmd_valid;
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (i_rst);
   property p_cpu_clk; o_cpu_clk_en == (o_mode == MODE_RUN); endproperty
   a_cpu_clk: assert property (p_cpu_clk) else $error("cpu clock outside run");
   property p_wait; quiet && i_wait_instr |=> o_mode == MODE_WAIT; endproperty
   a_wait: assert property (p_wait) else $error("wait not entered");
   property p_stop; quiet && !i_wait_instr && i_stop_instr && stop_en |=> o_mode == MODE_STOP;
   endproperty
   a_stop: assert property (p_stop) else $error("stop not entered");
   property p_no_stop; quiet && !i_wait_instr && i_stop_instr && !stop_en
      |=> o_illegal_reset && o_mode != MODE_STOP; endproperty
   a_no_stop: assert property (p_no_stop) else $error("stop without enable");
   property p_halt; o_mode == MODE_RUN && (i_halt_instr || i_breakpoint)
      |=> o_mode == MODE_DEBUG; endproperty
   a_halt: assert property (p_halt) else $error("debug entry missed");
   property p_wake; o_mode inside {MODE_WAIT, MODE_STOP} && wake
      |=> o_mode == MODE_RUN && o_pc_advance; endproperty
   a_wake: assert property (p_wake) else $error("wake missed");
   property p_act_cmd; i_dbg_cmd_valid && o_mode == MODE_RUN
      && i_dbg_cmd inside {CMD_REG, CMD_TRACE, CMD_GO}
      |=> o_dbg_cmd_error && !o_dbg_cmd_accept; endproperty
   a_act_cmd: assert property (p_act_cmd) else $error("command taken in run");
   property p_lp_cmd; i_dbg_cmd_valid && o_mode inside {MODE_WAIT, MODE_STOP}
      && i_dbg_cmd == CMD_MEM_STATUS |=> o_dbg_cmd_accept && o_dbg_cmd_error; endproperty
   a_lp_cmd: assert property (p_lp_cmd) else $error("status answer wrong");
   property p_tick; o_dbg_bit_tick |=> !o_dbg_bit_tick [*8] ##8 o_dbg_bit_tick; endproperty
   a_tick: assert property (p_tick) else $error("bit tick spacing");
endmodule : opmode_checker
bind operating_mode_controller opmode_checker chk_i (.*);

// [opmode_partner.sv]
// partner model: cpu event pulses, wake sources and debug host commands
`timescale 1ns/1ns
module opmode_partner
   import opmode_pkg::*;
(
   input wire logic i_core_clk,
   output logic [3:0] o_cpu_evt,
   output opmode_pkg::dbg_cmd_t o_cmd,
   output logic o_cmd_valid,
   output logic [7:0] o_irq,
   output logic [7:0] o_irq_enable
);
   // all quiet; the top wake source stays masked to prove masking
   initial begin
      o_cpu_evt = 4'h0;
      o_cmd = CMD_NONE;
      o_cmd_valid = 1'b0;
      o_irq = 8'h00;
      o_irq_enable = 8'h7F;
   end
   // one-cycle pulse: bit 0 wait, 1 stop, 2 halt, 3 breakpoint
   task cpu_pulse(input int k);
      @(posedge i_core_clk);
      o_cpu_evt[k] <= 1'b1;
      @(posedge i_core_clk);
      o_cpu_evt <= 4'h0;
   endtask : cpu_pulse
   // code scrambled once valid drops so a stale code is never trusted
   task send_cmd(input dbg_cmd_t c);
      @(posedge i_core_clk);
      o_cmd <= c;
      o_cmd_valid <= 1'b1;
      @(posedge i_core_clk);
      o_cmd <= dbg_cmd_t'(~c);
      o_cmd_valid <= 1'b0;
   endtask : send_cmd
   // interrupt request level for one cycle
   task raise_irq(input logic [7:0] v);
      @(posedge i_core_clk);
      o_irq <= v;
      @(posedge i_core_clk);
      o_irq <= 8'h00;
   endtask : raise_irq
endmodule : opmode_partner

// [test_operating_mode_controller.sv]
// testbench: mode sequencing, commands, wake and clock gating
`timescale 1ns/1ns
module test_operating_mode_controller;
   import opmode_pkg::*;
   logic clk, rst, pin, rd, wr, wreq, pcl, pca, ill, acc, err, cv, pw;
   logic [3:0] addr, evt;
   logic [31:0] wdata, rdata, rv;
   logic [15:0] pcv, last_pc;
   logic [7:0] irq, irqen;
   logic [8:0] lv;
   mode_t mode;
   dbg_cmd_t cmdv;
   int fail_count = 0, num_checks = 0, cycles = 0, n_ill = 0, k;
   operating_mode_controller #(.WAKE_DIV(8)) uut (
      .i_core_clk(clk), .i_rst(rst), .i_mode_pin(pin), .i_wait_instr(evt[0]),
      .i_stop_instr(evt[1]), .i_halt_instr(evt[2]), .i_breakpoint(evt[3]), .i_dbg_cmd(cmdv),
      .i_dbg_cmd_valid(cv), .i_irq(irq), .i_irq_enable(irqen), .i_avs_address(addr),
      .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata), .o_avs_readdata(rdata),
      .o_avs_waitrequest(wreq), .o_mode(mode), .o_cpu_clk_en(lv[8]), .o_sys_clk_en(lv[7]),
      .o_dbg_clk_en(lv[6]), .o_iref_on(lv[5]), .o_lpo_on(lv[4]), .o_ext_ref_on(lv[3]),
      .o_crystal_oscillator_on(lv[2]), .o_adc_on(lv[1]), .o_reg_full(lv[0]), .o_pc_load(pcl),
      .o_pc_value(pcv), .o_pc_advance(pca), .o_illegal_reset(ill), .o_dbg_cmd_accept(acc),
      .o_dbg_cmd_error(err), .o_dbg_bit_tick(), .o_periodic_wake(pw));
   opmode_partner p (.i_core_clk(clk), .o_cpu_evt(evt), .o_cmd(cmdv), .o_cmd_valid(cv),
      .o_irq(irq), .o_irq_enable(irqen));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // pulse capture and a hang guard
   always @(posedge clk) begin
      cycles++;
      if (pcl === 1'b1) last_pc <= pcv;
      n_ill += (ill === 1'b1);
      if (cycles == 5000) begin
         fail_count++;
         test_done();
      end
   end
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // one bus cycle, held until waitrequest is seen low
   task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      addr <= a;
      wr <= w;
      rd <= !w;
      wdata <= d;
      do begin
         @(posedge clk);
         n++;
      end while (wreq !== 1'b0 && n < 100);
      rv = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask : bus
   task cmd(input dbg_cmd_t c);
      p.send_cmd(c);
      #1;
   endtask : cmd
   task ev(input int k);
      p.cpu_pulse(k);
      #1;
   endtask : ev
   task wk(input logic [7:0] v);
      p.raise_irq(v);
      #1;
   endtask : wk
   task wait_mode(input mode_t m);
      int n;
      n = 0;
      while (mode !== m && n < 300) begin
         @(posedge clk);
         n++;
      end
      chk(mode, m);
      repeat (2) @(posedge clk);
      #1;
   endtask : wait_mode
   task test_done();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : test_done
   initial begin
      rst = 1'b1;
      pin = 1'b1;
      rd = 1'b0;
      wr = 1'b0;
      addr = 4'h0;
      wdata = 32'h0;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      wait_mode(MODE_RUN);
      chk(last_pc, START_ADDR);
      bus(1'b1, REG_CTRL, 32'hA5);
      bus(1'b0, REG_CTRL, 32'h0);
      chk(rv[7:0], 8'hA5);
      bus(1'b0, REG_CMD, 32'h0);
      chk(rv, 32'h0);
      bus(1'b0, REG_STATUS, 32'h0);
      chk(rv[1:0], MODE_RUN);
      // every command code except background and reset, while running
      for (k = 1; k < 7; k++) begin
         if (k != 3) begin
            cmd(dbg_cmd_t'(3'(k)));
            chk({acc, err}, k < 4 ? 2'b10 : 2'b01);
         end
      end
      $display("boot, registers and run commands done");
      bus(1'b1, REG_CTRL, 32'h0);
      ev(0);
      chk({mode, lv[8:7], lv[5], lv[0]}, {MODE_WAIT, 4'b0111});
      cmd(CMD_MEM);
      chk({acc, err}, 2'b01);
      cmd(CMD_MEM_STATUS);
      chk({acc, err}, 2'b11);
      wk(8'h80);
      chk(mode, MODE_WAIT);
      wk(8'h01);
      chk({mode, pca}, {MODE_RUN, 1'b1});
      ev(0);
      cmd(CMD_BACKGROUND);
      chk(mode, MODE_DEBUG);
      cmd(CMD_GO);
      chk(mode, MODE_RUN);
      for (k = 2; k < 4; k++) begin
         ev(k);
         chk({mode, lv[8]}, {MODE_DEBUG, 1'b0});
         cmd(CMD_GO);
      end
      $display("wait and debug entry done");
      bus(1'b1, REG_CTRL, 32'h01);
      ev(1);
      chk({mode, lv[7], lv[5], lv[2:0]}, {MODE_STOP, 5'b0});
      wk(8'h80);
      chk(mode, MODE_STOP);
      wk(8'h02);
      chk({mode, pca}, {MODE_RUN, 1'b1});
      bus(1'b1, REG_CTRL, 32'h61);
      bus(1'b1, REG_WAKE, 32'h08);
      ev(1);
      chk(lv[4:3], 2'b01);
      wk(8'h04);
      bus(1'b1, REG_WAKE, 32'h01);
      ev(1);
      wait_mode(MODE_RUN);
      // the wake cleared the flag; let one full period set it again
      repeat (8) @(posedge clk);
      bus(1'b0, REG_WAKE, 32'h0);
      chk(rv[4], 1'b1);
      chk(pw, 1'b1);
      // second clear: a tick meeting the first one keeps the flag set
      bus(1'b1, REG_WAKE, 32'h10);
      bus(1'b1, REG_WAKE, 32'h10);
      chk(pw, 1'b0);
      bus(1'b1, REG_CTRL, 32'h9D);
      ev(1);
      chk({mode, lv[6:5], lv[1:0]}, {MODE_STOP, 4'hF});
      cmd(CMD_MEM_STATUS);
      chk({acc, err}, 2'b11);
      cmd(CMD_BACKGROUND);
      chk(mode, MODE_DEBUG);
      cmd(CMD_GO);
      $display("stop modes done");
      bus(1'b1, REG_CTRL, 32'h0);
      k = n_ill;
      ev(1);
      chk(mode == MODE_STOP, 1'b0);
      repeat (2) @(posedge clk);
      chk(n_ill - k, 1);
      last_pc = 16'h0;
      cmd(CMD_FORCE_RESET);
      wait_mode(MODE_DEBUG);
      chk(last_pc, START_ADDR);
      // second reset with the mode pin held low
      @(posedge clk);
      pin <= 1'b0;
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      repeat (8) @(posedge clk);
      #1;
      chk({mode, lv[8]}, {MODE_DEBUG, 1'b0});
      cmd(CMD_GO);
      chk(mode, MODE_RUN);
      $display("illegal stop and resets done");
      test_done();
   end
endmodule : test_operating_mode_controller
